// File: dv/srb_status_bank_assertions.sv
`timescale 1ns/1ps
module srb_status_bank_checker (
   input logic ref_clk, // Clock
   input logic reset_n, // Reset, active low
   input logic [15:0] avs_address, // Byte address
   input logic avs_read, // Read request
   input logic avs_write, // Write request
   input logic [31:0] avs_readdata, // Read data
   input logic avs_waitrequest, // Wait request
   input logic system_clock_locked, // System lock
   input logic system_clock_cal_busy, // Calibration
   input logic analog_loop_zero_locked, // Lock
   input logic analog_loop_one_locked, // Lock
   input logic digital_loop_zero_freq_locked, // Lock
   input logic digital_loop_one_freq_locked, // Lock
   input logic phase_lock_detect_zero, // Lock
   input logic phase_lock_detect_one, // Lock
   input logic [4:0] digital_loop_zero_profile, // Profile
   input logic [4:0] digital_loop_one_profile, // Profile
   input logic channel_zero_locked, // Channel 0 lock
   input logic channel_one_locked, // Channel 1 lock
   input logic system_clock_stable // Stable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic take;
   logic [13:0] idx;
   assign take = avs_read && avs_waitrequest;
   assign idx = avs_address[15:2];
   AST_CH0_AND: assert property (channel_zero_locked == (system_clock_locked && analog_loop_zero_locked &&
      digital_loop_zero_freq_locked && phase_lock_detect_zero)) else $error("channel zero lock mismatch");
   AST_CH1_AND: assert property (channel_one_locked == (system_clock_locked && analog_loop_one_locked &&
      digital_loop_one_freq_locked && phase_lock_detect_one)) else $error("channel one lock mismatch");
   AST_STABLE_LOCK: assert property (system_clock_stable |-> system_clock_locked)
      else $error("stable without lock");
   AST_STABLE_LATE: assert property ($rose(system_clock_locked) |-> !system_clock_stable [*2])
      else $error("stable too early");
   AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("answer late");
   AST_DATA_HOLD: assert property (!take |=> $stable(avs_readdata))
      else $error("read data moved");
   AST_NV_RSVD: assert property (take && idx == 14'h3000 |=> avs_readdata[31:4] == 28'h0)
      else $error("reserved bits set");
   AST_CLK_READ: assert property (take && idx == 14'h3001 |=> avs_readdata == {26'h0,
      $past(channel_one_locked), $past(channel_zero_locked), 1'b0, $past(system_clock_cal_busy),
      $past(system_clock_stable), $past(system_clock_locked)}) else $error("clock status wrong");
   AST_PROF0: assert property (take && idx == 14'h3009 |=>
      avs_readdata == {27'h0, $past(digital_loop_zero_profile)}) else $error("profile zero wrong");
   AST_PROF1: assert property (take && idx == 14'h300a |=>
      avs_readdata == {27'h0, $past(digital_loop_one_profile)}) else $error("profile one wrong");
   cover property (take && idx == 14'h3000 ##1 avs_readdata[3]);
   cover property ($rose(system_clock_stable));
   cover property (take && idx == 14'h3001 ##1 avs_readdata[5]);
endmodule
bind srb_status_bank srb_status_bank_checker chk (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .system_clock_locked, .system_clock_cal_busy, .analog_loop_zero_locked,
   .analog_loop_one_locked, .digital_loop_zero_freq_locked, .digital_loop_one_freq_locked, .phase_lock_detect_zero,
   .phase_lock_detect_one, .digital_loop_zero_profile, .digital_loop_one_profile, .channel_zero_locked,
   .channel_one_locked, .system_clock_stable);

// File: dv/status_readback_bank_bench.sv
`timescale 1ns/1ps
module status_readback_bank_bench;
   logic ref_clk, reset_n, avs_read, avs_write, irq, avs_waitrequest, stb_exp;
   logic [15:0] avs_address, temperature;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata;
   logic nv_save_start, nv_load_start, nv_op_done, nv_crc_err, nv_gen_fault;
   logic system_clock_locked, system_clock_cal_busy, analog_loop_zero_locked, analog_loop_one_locked;
   logic digital_loop_zero_freq_locked, digital_loop_one_freq_locked, phase_lock_detect_zero, phase_lock_detect_one;
   logic aux_ref_fault, aux_lock_detect, channel_zero_locked, channel_one_locked, system_clock_stable;
   logic [5:0] ref_input_a_flags, ref_input_a_comp_flags, ref_input_b_flags, ref_input_b_comp_flags;
   logic [4:0] digital_loop_zero_profile, digital_loop_one_profile;
   logic [45:0] note;
   logic [45:0] note_q[$];
   int fail_count, total_checks, cycles;
   srb_status_bank uut (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .irq, .nv_save_start, .nv_load_start, .nv_op_done, .nv_crc_err, .nv_gen_fault,
      .system_clock_locked, .system_clock_cal_busy, .analog_loop_zero_locked, .analog_loop_one_locked,
      .digital_loop_zero_freq_locked, .digital_loop_one_freq_locked, .phase_lock_detect_zero, .phase_lock_detect_one,
      .aux_ref_fault, .aux_lock_detect, .temperature, .ref_input_a_flags, .ref_input_a_comp_flags, .ref_input_b_flags,
      .ref_input_b_comp_flags, .digital_loop_zero_profile, .digital_loop_one_profile, .channel_zero_locked,
      .channel_one_locked, .system_clock_stable);
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Bus master and stimulus helpers
   // ------------------------------------------------------------------
   task automatic bus(input logic wr, input logic [13:0] idx, input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= d;
      avs_byteenable <= be;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      // Hold the request until waitrequest is sampled low; the cycle ceiling ends a hang
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [13:0] idx, input logic [31:0] e);
      note_q.push_back({idx, e});
      bus(1'b0, idx, 32'h0, 4'hf);
   endtask
   task automatic wr(input logic [13:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d, 4'h3);
   endtask
   task automatic pulse(input logic [4:0] v);
      @(posedge ref_clk);
      {nv_save_start, nv_load_start, nv_op_done, nv_crc_err, nv_gen_fault} <= v;
      @(posedge ref_clk);
      {nv_save_start, nv_load_start, nv_op_done, nv_crc_err, nv_gen_fault} <= 5'h0;
   endtask
   task automatic chk_irq(input logic e);
      @(negedge ref_clk);
      total_checks++;
      if (irq !== e) begin
         fail_count++;
         $display("wrong value irq expected %b seen %b", e, irq);
      end
   endtask
   function automatic logic [31:0] clk_exp();
      return {26'h0, system_clock_locked & analog_loop_one_locked & digital_loop_one_freq_locked & phase_lock_detect_one,
         system_clock_locked & analog_loop_zero_locked & digital_loop_zero_freq_locked & phase_lock_detect_zero,
         1'b0, system_clock_cal_busy, stb_exp, system_clock_locked};
   endfunction
   // ------------------------------------------------------------------
   // Result watcher and hang limit
   // ------------------------------------------------------------------
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_of_test();
      end
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && note_q.size() > 0) begin
         note = note_q.pop_front();
         total_checks++;
         if (avs_readdata !== note[31:0]) begin
            fail_count++;
            $display("wrong value reg %h expected %h seen %h", note[45:32], note[31:0], avs_readdata);
         end
      end
   end
   initial begin
      void'($urandom(81947));
      {reset_n, avs_read, avs_write, nv_save_start, nv_load_start, nv_op_done, nv_crc_err, nv_gen_fault, stb_exp} = '0;
      {system_clock_locked, system_clock_cal_busy, analog_loop_zero_locked, analog_loop_one_locked} = '0;
      {digital_loop_zero_freq_locked, digital_loop_one_freq_locked, phase_lock_detect_zero, phase_lock_detect_one} = '0;
      {aux_ref_fault, aux_lock_detect, avs_address, temperature, avs_byteenable, avs_writedata} = '0;
      {ref_input_a_flags, ref_input_a_comp_flags, ref_input_b_flags, ref_input_b_comp_flags} = '0;
      {digital_loop_zero_profile, digital_loop_one_profile} = '0;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(14'h3012, 32'h0000000a);
      rd(14'h3020, 32'h0);
      wr(14'h3010, 32'hff);
      pulse(5'h10);
      rd(14'h3000, 32'h1);
      pulse(5'h02);
      rd(14'h3000, 32'h9);
      pulse(5'h04);
      rd(14'h3000, 32'h8);
      pulse(5'h08);
      rd(14'h3000, 32'h2);
      pulse(5'h01);
      rd(14'h3000, 32'h6);
      pulse(5'h04);
      rd(14'h3000, 32'h4);
      wr(14'h3000, 32'hff);
      rd(14'h3000, 32'h4);
      pulse(5'h12);
      rd(14'h3000, 32'h9);
      pulse(5'h04);
      rd(14'h3000, 32'h8);
      rd(14'h3010, 32'h0f);
      chk_irq(1'b0);
      wr(14'h3011, 32'h04);
      chk_irq(1'b1);
      wr(14'h3010, 32'h04);
      chk_irq(1'b0);
      rd(14'h3010, 32'h0b);
      wr(14'h3011, 32'h0);
      // Stability timer of two ticks, then lock
      wr(14'h3012, 32'h2);
      system_clock_locked <= 1'b1;
      repeat (100) @(posedge ref_clk);
      rd(14'h3001, clk_exp());
      repeat (400) @(posedge ref_clk);
      stb_exp = 1'b1;
      rd(14'h3001, clk_exp());
      for (int i = 0; i < 16; i++) begin
         {analog_loop_zero_locked, analog_loop_one_locked, digital_loop_zero_freq_locked, digital_loop_one_freq_locked,
            phase_lock_detect_zero, phase_lock_detect_one} <= 6'($urandom | $urandom);
         {system_clock_cal_busy, aux_ref_fault, aux_lock_detect} <= 3'($urandom);
         temperature <= 16'($urandom);
         {ref_input_a_flags, ref_input_a_comp_flags, ref_input_b_flags, ref_input_b_comp_flags} <= 24'($urandom);
         digital_loop_zero_profile <= 5'h1 << ($urandom % 5);
         digital_loop_one_profile <= 5'h1 << ($urandom % 5);
         @(posedge ref_clk);
         rd(14'h3001, clk_exp());
         rd(14'h3002, {30'h0, aux_lock_detect, aux_ref_fault});
         rd(14'h3003, {24'h0, temperature[7:0]});
         rd(14'h3004, {24'h0, temperature[15:8]});
         rd(14'h3005, {26'h0, ref_input_a_flags});
         rd(14'h3006, {26'h0, ref_input_a_comp_flags});
         rd(14'h3007, {26'h0, ref_input_b_flags});
         rd(14'h3008, {26'h0, ref_input_b_comp_flags});
         rd(14'h3009, {27'h0, digital_loop_zero_profile});
         rd(14'h300a, {27'h0, digital_loop_one_profile});
      end
      // Drop channel locks and reference faults, clear their events, then lose system lock
      {analog_loop_zero_locked, analog_loop_one_locked} <= 2'b00;
      {ref_input_a_flags, ref_input_a_comp_flags, ref_input_b_flags, ref_input_b_comp_flags} <= 24'h000000;
      wr(14'h3010, 32'hff);
      system_clock_locked <= 1'b0;
      stb_exp = 1'b0;
      @(posedge ref_clk);
      rd(14'h3001, clk_exp());
      rd(14'h3010, 32'h10);
      end_of_test();
   end
endmodule

// File: verilog/srb_consts.vh
`ifndef SRB_CONSTS_VH
`define SRB_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SRB_IDX_NV_STATUS 14'h3000
`define SRB_IDX_CLOCK_LOCK 14'h3001
`define SRB_IDX_AUX_LOOP 14'h3002
`define SRB_IDX_TEMP_LOW 14'h3003
`define SRB_IDX_TEMP_HIGH 14'h3004
`define SRB_IDX_REF_A 14'h3005
`define SRB_IDX_REF_A_COMP 14'h3006
`define SRB_IDX_REF_B 14'h3007
`define SRB_IDX_REF_B_COMP 14'h3008
`define SRB_IDX_LOOP0_PROFILE 14'h3009
`define SRB_IDX_LOOP1_PROFILE 14'h300a
`define SRB_IDX_IRQ_STATUS 14'h3010
`define SRB_IDX_IRQ_MASK 14'h3011
`define SRB_IDX_STABLE_TIME 14'h3012

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SRB_NV_SAVE_BIT 0
`define SRB_NV_LOAD_BIT 1
`define SRB_NV_FAULT_BIT 2
`define SRB_NV_CRC_BIT 3
`define SRB_CLK_LOCKED_BIT 0
`define SRB_CLK_STABLE_BIT 1
`define SRB_CLK_CAL_BIT 2
`define SRB_CLK_CH0_BIT 4
`define SRB_CLK_CH1_BIT 5
`define SRB_EV_SAVE_DONE 0
`define SRB_EV_LOAD_DONE 1
`define SRB_EV_NV_FAULT 2
`define SRB_EV_NV_CRC 3
`define SRB_EV_CLK_LOST 4
`define SRB_EV_CH0_LOST 5
`define SRB_EV_CH1_LOST 6
`define SRB_EV_REF_FAULT 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SRB_IRQ_STATUS_RST 8'h00
`define SRB_IRQ_MASK_RST 8'h00
`define SRB_STABLE_TIME_RST 16'h000a

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SRB_CLK_PERIOD_NS 5
`define SRB_STABLE_TICK_NS 1000
`define SRB_STABLE_TICK_CYCLES ((`SRB_STABLE_TICK_NS + `SRB_CLK_PERIOD_NS - 1) / `SRB_CLK_PERIOD_NS)

`endif

// File: verilog/srb_nv_tracker.v
`timescale 1ns/1ps
module srb_nv_tracker (
   input wire ref_clk, // System clock
   input wire reset_n, // Asynchronous reset, active low
   input wire save_start, // Pulse: save to store begins
   input wire load_start, // Pulse: load from store begins
   input wire op_done, // Pulse: current store operation ends
   input wire crc_err, // Pulse: checksum error seen
   input wire gen_fault, // Pulse: other store error seen
   output reg save_busy, // Save in progress
   output reg load_busy, // Load in progress
   output reg crc_flag, // Checksum error held
   output reg fault_flag // General error held
);
   wire op_start;

   assign op_start = save_start | load_start;

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         save_busy <= 1'b0;
         load_busy <= 1'b0;
         crc_flag <= 1'b0;
         fault_flag <= 1'b0;
      end else begin
         if (save_start) begin
            save_busy <= 1'b1;
         end else if (op_done) begin
            save_busy <= 1'b0;
         end
         if (load_start) begin
            load_busy <= 1'b1;
         end else if (op_done) begin
            load_busy <= 1'b0;
         end
         // Error flags clear only when a new operation begins; a new error wins
         crc_flag <= crc_err | (crc_flag & ~op_start);
         fault_flag <= gen_fault | (fault_flag & ~op_start);
      end
   end
endmodule

// File: verilog/srb_stable_timer.v
`timescale 1ns/1ps
`include "srb_consts.vh"
module srb_stable_timer (
   input wire ref_clk, // System clock
   input wire reset_n, // Asynchronous reset, active low
   input wire locked, // Instantaneous loop lock
   input wire [15:0] interval, // Required lock time in ticks
   output wire stable // Lock held long enough
);
   localparam [7:0] TICK_LAST = 8'd199;

   reg [7:0] pre_reg;
   reg [15:0] cnt_reg;
   reg stable_reg;
   wire tick;

   // ----------------------------------------------------------------------
   // Tick divider, restarted whenever lock drops so no partial tick counts
   // ----------------------------------------------------------------------
   assign tick = (pre_reg == TICK_LAST);

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_reg <= 8'h00;
         cnt_reg <= 16'h0000;
         stable_reg <= 1'b0;
      end else if (!locked) begin
         pre_reg <= 8'h00;
         cnt_reg <= 16'h0000;
         stable_reg <= 1'b0;
      end else begin
         pre_reg <= tick ? 8'h00 : pre_reg + 8'h01;
         if (tick && cnt_reg != 16'hffff) begin
            cnt_reg <= cnt_reg + 16'h0001;
         end
         stable_reg <= (cnt_reg >= interval);
      end
   end

   assign stable = stable_reg & locked;
endmodule

// File: verilog/srb_status_bank.v
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "srb_consts.vh"
// What this block does
// - Checksum error during store operation sets bit 3
// - Other store error sets bit 2
// - Store error flags hold until next operation
// - Bit 1 high while load runs
// - Bit 0 high while save runs
// - All status bits read-only and live
// - Clock bit 5 is channel one lock AND
// - Loop zero profile bits show active profile
// - Loop one profile bits show active profile
// - Clock bit 4 is channel zero lock AND
// - Clock bit 2 shows oscillator calibration
// - Bit 1 stable after timer; bit 0 lock
module srb_status_bank (
   input wire ref_clk, // System clock, 200 MHz
   input wire reset_n, // Asynchronous reset, active low
   input wire [15:0] avs_address, // Avalon byte address
   input wire avs_read, // Avalon read request
   input wire avs_write, // Avalon write request
   input wire [3:0] avs_byteenable, // Avalon byte enables
   input wire [31:0] avs_writedata, // Avalon write data
   output reg [31:0] avs_readdata, // Avalon read data
   output wire avs_waitrequest, // Avalon wait request
   output wire irq, // Level interrupt, high while unmasked event pending
   input wire nv_save_start, // Pulse: save to store begins
   input wire nv_load_start, // Pulse: load from store begins
   input wire nv_op_done, // Pulse: store operation ends
   input wire nv_crc_err, // Pulse: checksum error
   input wire nv_gen_fault, // Pulse: other store error
   input wire system_clock_locked, // System clock loop lock
   input wire system_clock_cal_busy, // Oscillator calibration running
   input wire analog_loop_zero_locked, // Channel 0 analog loop lock
   input wire analog_loop_one_locked, // Channel 1 analog loop lock
   input wire digital_loop_zero_freq_locked, // Channel 0 digital loop frequency lock
   input wire digital_loop_one_freq_locked, // Channel 1 digital loop frequency lock
   input wire phase_lock_detect_zero, // Channel 0 phase lock detect
   input wire phase_lock_detect_one, // Channel 1 phase lock detect
   input wire aux_ref_fault, // Auxiliary loop reference fault
   input wire aux_lock_detect, // Auxiliary loop lock
   input wire [15:0] temperature, // Internal temperature
   input wire [5:0] ref_input_a_flags, // Loss, valid, fault, jitter, fast, slow
   input wire [5:0] ref_input_a_comp_flags, // Same layout
   input wire [5:0] ref_input_b_flags, // Same layout
   input wire [5:0] ref_input_b_comp_flags, // Same layout
   input wire [4:0] digital_loop_zero_profile, // One-hot active profile, loop 0
   input wire [4:0] digital_loop_one_profile, // One-hot active profile, loop 1
   output wire channel_zero_locked, // Channel 0 fully locked
   output wire channel_one_locked, // Channel 1 fully locked
   output wire system_clock_stable // Lock held past stability time
);
   // ----------------------------------------------------------------------
   // Local storage
   // ----------------------------------------------------------------------
   localparam FLAG_FAULT = 3;

   reg ack_reg;
   reg [7:0] irq_status_reg;
   reg [7:0] irq_status_next;
   reg [7:0] irq_mask_reg;
   reg [15:0] stable_time_reg;
   reg [7:0] prev_reg;
   reg [31:0] read_mux;
   reg ref_fault_any;
   wire [13:0] index;
   wire accept;
   wire wr_accept;
   wire save_busy;
   wire load_busy;
   wire crc_flag;
   wire fault_flag;
   wire [7:0] nv_byte;
   wire [7:0] clock_byte;
   wire [7:0] aux_byte;
   wire [7:0] watch;
   wire [7:0] events;

   // ----------------------------------------------------------------------
   // Store status tracking
   // ----------------------------------------------------------------------
   srb_nv_tracker u_nv (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .save_start(nv_save_start),
      .load_start(nv_load_start),
      .op_done(nv_op_done),
      .crc_err(nv_crc_err),
      .gen_fault(nv_gen_fault),
      .save_busy(save_busy),
      .load_busy(load_busy),
      .crc_flag(crc_flag),
      .fault_flag(fault_flag)
   );

   // ----------------------------------------------------------------------
   // System clock stability timer
   // ----------------------------------------------------------------------
   srb_stable_timer u_stable (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .locked(system_clock_locked),
      .interval(stable_time_reg),
      .stable(system_clock_stable)
   );

   // ----------------------------------------------------------------------
   // Lock summaries
   // ----------------------------------------------------------------------
   assign channel_zero_locked = system_clock_locked & analog_loop_zero_locked &
      digital_loop_zero_freq_locked & phase_lock_detect_zero;
   assign channel_one_locked = system_clock_locked & analog_loop_one_locked &
      digital_loop_one_freq_locked & phase_lock_detect_one;

   // ----------------------------------------------------------------------
   // Live register images
   // ----------------------------------------------------------------------
   assign nv_byte = {4'h0, crc_flag, fault_flag, load_busy, save_busy};
   assign clock_byte = {2'b00, channel_one_locked, channel_zero_locked, 1'b0,
      system_clock_cal_busy, system_clock_stable, system_clock_locked};
   assign aux_byte = {6'h00, aux_lock_detect, aux_ref_fault};

   // ----------------------------------------------------------------------
   // Bus decode and handshake
   // ----------------------------------------------------------------------
   assign index = avs_address[15:2];
   // One wait cycle per request, then the answer stands for the accept edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign accept = (avs_read | avs_write) & ~ack_reg;
   assign wr_accept = avs_write & ack_reg;

   // ----------------------------------------------------------------------
   // Read multiplexer; every image is sampled live at read time
   // ----------------------------------------------------------------------
   always @* begin
      read_mux = 32'h0000_0000;
      case (index)
         `SRB_IDX_NV_STATUS: begin
            read_mux = {24'h00_0000, nv_byte};
         end
         `SRB_IDX_CLOCK_LOCK: begin
            read_mux = {24'h00_0000, clock_byte};
         end
         `SRB_IDX_AUX_LOOP: begin
            read_mux = {24'h00_0000, aux_byte};
         end
         `SRB_IDX_TEMP_LOW: begin
            read_mux = {24'h00_0000, temperature[7:0]};
         end
         `SRB_IDX_TEMP_HIGH: begin
            read_mux = {24'h00_0000, temperature[15:8]};
         end
         `SRB_IDX_REF_A: begin
            read_mux = {26'h000_0000, ref_input_a_flags};
         end
         `SRB_IDX_REF_A_COMP: begin
            read_mux = {26'h000_0000, ref_input_a_comp_flags};
         end
         `SRB_IDX_REF_B: begin
            read_mux = {26'h000_0000, ref_input_b_flags};
         end
         `SRB_IDX_REF_B_COMP: begin
            read_mux = {26'h000_0000, ref_input_b_comp_flags};
         end
         `SRB_IDX_LOOP0_PROFILE: begin
            read_mux = {27'h000_0000, digital_loop_zero_profile};
         end
         `SRB_IDX_LOOP1_PROFILE: begin
            read_mux = {27'h000_0000, digital_loop_one_profile};
         end
         `SRB_IDX_IRQ_STATUS: begin
            read_mux = {24'h00_0000, irq_status_reg};
         end
         `SRB_IDX_IRQ_MASK: begin
            read_mux = {24'h00_0000, irq_mask_reg};
         end
         `SRB_IDX_STABLE_TIME: begin
            read_mux = {16'h0000, stable_time_reg};
         end
         default: begin
            read_mux = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_reg <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack_reg <= accept;
         if (avs_read && accept) begin
            avs_readdata <= read_mux;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Writable control registers; status bank writes fall through unused
   // ----------------------------------------------------------------------
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_mask_reg <= `SRB_IRQ_MASK_RST;
         stable_time_reg <= `SRB_STABLE_TIME_RST;
      end else if (wr_accept) begin
         case (index)
            `SRB_IDX_IRQ_MASK: begin
               if (avs_byteenable[0]) begin
                  irq_mask_reg <= avs_writedata[7:0];
               end
            end
            `SRB_IDX_STABLE_TIME: begin
               if (avs_byteenable[0]) begin
                  stable_time_reg[7:0] <= avs_writedata[7:0];
               end
               if (avs_byteenable[1]) begin
                  stable_time_reg[15:8] <= avs_writedata[15:8];
               end
            end
            default: begin
               irq_mask_reg <= irq_mask_reg;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Event detection
   // ----------------------------------------------------------------------
   always @* begin
      ref_fault_any = ref_input_a_flags[FLAG_FAULT] | ref_input_a_comp_flags[FLAG_FAULT] |
         ref_input_b_flags[FLAG_FAULT] | ref_input_b_comp_flags[FLAG_FAULT];
   end

   // Watched levels: rising edge of each is an event (lock and busy bits inverted)
   assign watch = {ref_fault_any, ~channel_one_locked, ~channel_zero_locked,
      ~system_clock_locked, crc_flag, fault_flag, ~load_busy, ~save_busy};
   assign events = watch & ~prev_reg;

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_reg <= 8'hff;
      end else begin
         prev_reg <= watch;
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt status, write one to clear; a new event beats the clear
   // ----------------------------------------------------------------------
   always @* begin
      irq_status_next = irq_status_reg;
      if (wr_accept && index == `SRB_IDX_IRQ_STATUS && avs_byteenable[0]) begin
         irq_status_next = irq_status_reg & ~avs_writedata[7:0];
      end
      irq_status_next = irq_status_next | events;
   end

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_reg <= `SRB_IRQ_STATUS_RST;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   assign irq = |(irq_status_reg & irq_mask_reg);
endmodule
